// ### wae_params.svh
`ifndef WAE_PARAMS_SVH
`define WAE_PARAMS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define WAE_CLK_NS 25
`define WAE_STEP_NS 85937500
`define WAE_STEP_CYC (`WAE_STEP_NS / `WAE_CLK_NS)
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define WAE_A_STS1 8'h00
`define WAE_A_STS3 8'h04
`define WAE_A_STS5 8'h08
`define WAE_A_STS6 8'h0C
`define WAE_A_EN1 8'h10
`define WAE_A_EN3 8'h14
`define WAE_A_EN5 8'h18
`define WAE_A_EN6 8'h1C
`define WAE_A_PSTS 8'h20
`define WAE_A_PEN 8'h24
`define WAE_A_SMI2 8'h28
`define WAE_A_PCTL 8'h2C
`define WAE_A_POL 8'h30
`define WAE_A_EITHER_EDGE_TRIGGER 8'h34
`define WAE_A_MWAKE 8'h38
`define WAE_A_DCLK 8'h3C
`define WAE_A_CLKCFG 8'h40
`define WAE_A_KRG 8'h44
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define WAE_B_GRP 3
`define WAE_B_ROUTE 5
`define WAE_B_KEYEN 7
`define WAE_B_KEY 0
`define WAE_B_MSE 1
`define WAE_B_FUNC 0
`define WAE_B_POL 1
`define WAE_B_PP 7
`define WAE_B_SWAP 2
`define WAE_B_LOCK 7
`define WAE_B_OFF 0
`define WAE_B_ISO 1
`define WAE_B_KRST 6
`define WAE_DCLK_RST 6'h0B
`define WAE_ZERO_HI 24'h00_0000
`endif

// ### wae_pkg.sv
package wae_pkg;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic clk;
      logic dat;
   } wae_ps2_t;

   typedef enum logic [1:0] {
      WAE_SEL_ANY = 2'b00,
      WAE_SEL_LEFT = 2'b01,
      WAE_SEL_RIGHT = 2'b10,
      WAE_SEL_DBL = 2'b11
   } wae_msel_t;

   typedef enum logic {
      WAE_M_IDLE = 1'b0,
      WAE_M_WAIT = 1'b1
   } wae_mst_t;

   typedef struct packed {
      logic [7:0] sts1, sts3, sts5, sts6;
      logic [7:0] en1, en3, en5, en6;
      logic pin_sts, pin_en;
      logic [7:0] smi2, pctl, pol, either_edge_trigger;
      logic [7:0] mwake, clkcfg, krg;
      logic [5:0] dclk;
      wae_mst_t mst;
      logic [21:0] mpre;
      logic [5:0] mcnt;
      logic ack;
      logic [7:0] rdat;
      logic wake, wake_oe_n;
      wae_ps2_t kbc_m, kbc_k;
      logic kbc_rst;
   } wae_state_t;
endpackage : wae_pkg

// ### wae_sync_edge.sv
`timescale 1ns/100ps
module wae_sync_edge #(
   parameter int W = 8
) (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] rise_out,
   output logic [W-1:0] fall_out
);
   typedef struct packed {
      logic [W-1:0] s1, s2, s3;
   } wae_sync_st_t;
   wae_sync_st_t q, nxt_q;

   // ----------------------------------------
   // Two-stage sync, edge from stages 2 and 3
   // ----------------------------------------
   always_comb begin
      nxt_q = q;
      nxt_q.s1 = pin_in;
      nxt_q.s2 = q.s1;
      nxt_q.s3 = q.s2;
      if (sys_rst_in) begin
         nxt_q = '0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      q <= nxt_q;
   end

   // One pulse per edge, stage 1 never looked at
   assign rise_out = q.s2 & ~q.s3;
   assign fall_out = ~q.s2 & q.s3;
endmodule : wae_sync_edge

// ### wae_core.sv
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`include "wae_params.svh"
module wae_core #(
   parameter int STEP_CYC = `WAE_STEP_CYC
) (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic bat_por_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic [7:0] gpio_wake_in,
   input wire logic [7:0] evt5_in,
   input wire logic grp_irq_in,
   input wire logic key_evt_in,
   input wire logic [1:0] mouse_btn_in,
   input wire logic gp_pin_val_in,
   input wire logic gp_pin_oe_n_in,
   input wire wae_pkg::wae_ps2_t aux_port_in,
   input wire wae_pkg::wae_ps2_t kbd_port_in,
   output wae_pkg::wae_ps2_t kbc_mouse_out,
   output wae_pkg::wae_ps2_t kbc_kbd_out,
   output logic kbc_reset_out,
   output logic wake_request_out,
   output logic wake_request_oe_n_out
);
   wae_pkg::wae_state_t q, s;
   logic [7:0] rise, fall, gset;
   logic req, wr, hit, dbl, locked, dwr, act, lvl;
   logic [7:0] wd, s6;
   wae_pkg::wae_ps2_t mse, kbd;
   localparam logic [21:0] STEP_LAST = 22'(STEP_CYC - 1);

   function automatic logic [7:0] w1c(input logic [7:0] old,
      input logic [7:0] set, input logic hit_w,
      input logic [7:0] d);
      // Set wins over a clear in the same cycle
      w1c = (old & ~(hit_w ? d : 8'h00)) | set;
   endfunction : w1c

   wae_sync_edge #(.W(8)) u_sync (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .pin_in(gpio_wake_in),
      .rise_out(rise),
      .fall_out(fall)
   );

   // ----------------------------------------
   // Event and bus decode
   // ----------------------------------------
   always_comb begin
      req = wb_cyc_in & wb_stb_in & ~q.ack;
      wr = req & wb_we_in & wb_sel_in[0];
      wd = wb_dat_in[7:0];
      locked = q.mwake[`WAE_B_LOCK];
      dwr = wr && wb_adr_in == `WAE_A_DCLK && !locked;
      dbl = q.mwake[1:0] == wae_pkg::WAE_SEL_DBL;
      gset = (rise & ~q.pol & ~q.either_edge_trigger)
         | (fall & q.pol & ~q.either_edge_trigger)
         | ((rise | fall) & q.either_edge_trigger);
      act = q.pin_sts & q.pin_en;
      lvl = q.pctl[`WAE_B_POL] ? act : ~act;
      mse = q.mwake[`WAE_B_SWAP] ? kbd_port_in : aux_port_in;
      kbd = q.mwake[`WAE_B_SWAP] ? aux_port_in : kbd_port_in;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s = q;
      hit = 1'b0;
      s.ack = req;
      if (req) begin
         case (wb_adr_in)
            `WAE_A_STS1: s.rdat = q.sts1;
            `WAE_A_STS3: s.rdat = q.sts3;
            `WAE_A_STS5: s.rdat = q.sts5;
            `WAE_A_STS6: s.rdat = q.sts6;
            `WAE_A_EN1: s.rdat = q.en1;
            `WAE_A_EN3: s.rdat = q.en3;
            `WAE_A_EN5: s.rdat = q.en5;
            `WAE_A_EN6: s.rdat = q.en6;
            `WAE_A_PSTS: s.rdat = {7'h00, q.pin_sts};
            `WAE_A_PEN: s.rdat = {7'h00, q.pin_en};
            `WAE_A_SMI2: s.rdat = q.smi2;
            `WAE_A_PCTL: s.rdat = q.pctl;
            `WAE_A_POL: s.rdat = q.pol;
            `WAE_A_EITHER_EDGE_TRIGGER: s.rdat = q.either_edge_trigger;
            `WAE_A_MWAKE: s.rdat = q.mwake;
            `WAE_A_DCLK: s.rdat = {2'b00, q.dclk};
            `WAE_A_CLKCFG: s.rdat = q.clkcfg;
            `WAE_A_KRG: s.rdat = q.krg;
            default: s.rdat = 8'h00;
         endcase
      end

      // Mouse click wake, held idle while off
      if (q.clkcfg[`WAE_B_OFF] || dwr) begin
         s.mst = wae_pkg::WAE_M_IDLE;
         s.mpre = '0;
         s.mcnt = '0;
      end else begin
         case (q.mst)
            wae_pkg::WAE_M_IDLE: begin
               if (dbl && mouse_btn_in[0]) begin
                  s.mst = wae_pkg::WAE_M_WAIT;
                  s.mpre = '0;
                  s.mcnt = q.dclk;
               end
            end
            wae_pkg::WAE_M_WAIT: begin
               if (mouse_btn_in[0]) begin
                  hit = 1'b1;
                  s.mst = wae_pkg::WAE_M_IDLE;
               end else if (q.mpre == STEP_LAST) begin
                  s.mpre = '0;
                  if (q.mcnt == 6'h00) begin
                     s.mst = wae_pkg::WAE_M_IDLE;
                  end else begin
                     s.mcnt = q.mcnt - 6'h01;
                  end
               end else begin
                  s.mpre = q.mpre + 22'h1;
               end
            end
            default: s.mst = wae_pkg::WAE_M_IDLE;
         endcase
         case (q.mwake[1:0])
            wae_pkg::WAE_SEL_ANY: hit = |mouse_btn_in;
            wae_pkg::WAE_SEL_LEFT: hit = mouse_btn_in[0];
            wae_pkg::WAE_SEL_RIGHT: hit = mouse_btn_in[1];
            default: hit = hit;
         endcase
      end

      // Sticky status, write one to clear
      s.sts1 = w1c(q.sts1, gset,
         wr && wb_adr_in == `WAE_A_STS1, wd);
      s.sts5 = w1c(q.sts5, evt5_in,
         wr && wb_adr_in == `WAE_A_STS5, wd);
      s6 = w1c({6'h00, q.sts6[1:0]},
         {6'h00, hit, key_evt_in & q.sts6[`WAE_B_KEYEN]},
         wr && wb_adr_in == `WAE_A_STS6, wd);
      s.sts6[1:0] = s6[1:0];
      // Group line is live, not sticky
      s.sts3 = 8'h00;
      s.sts3[`WAE_B_GRP] = grp_irq_in & q.smi2[`WAE_B_ROUTE];
      s.pin_sts = |(q.sts1 & q.en1)
         | |(q.sts3 & q.en3)
         | |(q.sts5 & q.en5)
         | |(q.sts6[1:0] & q.en6[1:0])
         | (q.pin_sts & ~(wr && wb_adr_in == `WAE_A_PSTS && wd[0]));

      if (wr) begin
         case (wb_adr_in)
            `WAE_A_STS6: s.sts6[`WAE_B_KEYEN] = wd[`WAE_B_KEYEN];
            `WAE_A_EN1: s.en1 = wd;
            `WAE_A_EN3: s.en3 = wd;
            `WAE_A_EN5: s.en5 = wd;
            `WAE_A_EN6: s.en6 = wd;
            `WAE_A_PEN: s.pin_en = wd[0];
            `WAE_A_SMI2: s.smi2 = wd;
            `WAE_A_PCTL: s.pctl = wd;
            `WAE_A_POL: s.pol = wd;
            `WAE_A_EITHER_EDGE_TRIGGER: s.either_edge_trigger = wd;
            `WAE_A_MWAKE: if (!locked) s.mwake = wd;
            `WAE_A_DCLK: if (!locked) s.dclk = wd[5:0];
            `WAE_A_CLKCFG: s.clkcfg = wd;
            `WAE_A_KRG: s.krg = wd;
            default: s.rdat = s.rdat;
         endcase
      end

      // Shared pin: GPIO pass-through or wake output
      if (q.pctl[`WAE_B_FUNC]) begin
         if (q.pctl[`WAE_B_PP]) begin
            s.wake = lvl;
            s.wake_oe_n = 1'b0;
         end else begin
            s.wake = 1'b0;
            s.wake_oe_n = lvl;
         end
      end else begin
         s.wake = gp_pin_val_in;
         s.wake_oe_n = gp_pin_oe_n_in;
      end
      // Isolated mouse lines float idle high
      s.kbc_m = q.krg[`WAE_B_ISO] ? '1 : mse;
      s.kbc_k = kbd;
      s.kbc_rst = q.krg[`WAE_B_KRST];

      // Standby reset spares battery settings
      if (sys_rst_in) begin
         s = '0;
         s.wake_oe_n = 1'b1;
         s.kbc_m = '1;
         s.kbc_k = '1;
         s.sts6[`WAE_B_KEYEN] = q.sts6[`WAE_B_KEYEN];
         s.mwake = q.mwake;
         s.dclk = q.dclk;
      end
      if (bat_por_in) begin
         s.sts6[`WAE_B_KEYEN] = 1'b0;
         s.mwake = 8'h00;
         s.dclk = `WAE_DCLK_RST;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      q <= s;
   end

   assign wb_dat_out = {`WAE_ZERO_HI, q.rdat};
   assign wb_ack_out = q.ack;
   assign kbc_mouse_out = q.kbc_m;
   assign kbc_kbd_out = q.kbc_k;
   assign kbc_reset_out = q.kbc_rst;
   assign wake_request_out = q.wake;
   assign wake_request_oe_n_out = q.wake_oe_n;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);

   a_ack_pulse: assert property (req |=> wb_ack_out ##1 !wb_ack_out)
      else $error("ack not a single cycle");
   a_sts_sticky: assert property (
      q.sts1[0] && !(wr && wb_adr_in == `WAE_A_STS1) |=> q.sts1[0])
      else $error("status bit lost without clear");
   a_pin_set: assert property (
      |(q.sts5 & q.en5) |=> q.pin_sts)
      else $error("pin status not set");
   a_wake_low: assert property (
      act && q.pctl == 8'h01 |=> !wake_request_oe_n_out
      && !wake_request_out)
      else $error("wake output not driven low");
   a_gpio_rise: assert property (
      rise[0] && !q.pol[0] && !q.either_edge_trigger[0] |=> q.sts1[0])
      else $error("rising edge missed");
   a_either_edge: assert property (
      fall[1] && q.either_edge_trigger[1] |=> q.sts1[1])
      else $error("either-edge fall missed");
   a_grp_route: assert property (
      q.smi2[`WAE_B_ROUTE] |=> q.sts3[`WAE_B_GRP] == $past(grp_irq_in))
      else $error("group status not mirrored");
   a_mouse_off: assert property (
      q.clkcfg[`WAE_B_OFF] |=> q.mst == wae_pkg::WAE_M_IDLE
      && q.mpre == 22'h0)
      else $error("mouse logic ran while off");
   a_dclk_reset: assert property (
      dwr |=> q.mst == wae_pkg::WAE_M_IDLE)
      else $error("interval write left mouse logic running");
   a_iso_block: assert property (
      q.krg[`WAE_B_ISO] |=> kbc_mouse_out == 2'b11)
      else $error("isolated mouse lines reached controller");
   // Battery reset may still clear locked settings
   a_lock_hold: assert property (
      locked && !bat_por_in |=> $stable(q.mwake) && $stable(q.dclk))
      else $error("locked mouse settings changed");
   a_sts_clear: assert property (
      wr && wb_adr_in == `WAE_A_STS1 && wd == 8'hFF && gset == 8'h00
      |=> q.sts1 == 8'h00)
      else $error("status not cleared by write of one");
   a_gset_latch: assert property (
      gset != 8'h00 |=> (q.sts1 & $past(gset)) == $past(gset))
      else $error("gpio edge not latched");
   a_fall_pol: assert property (
      fall[0] && q.pol[0] && !q.either_edge_trigger[0] |=> q.sts1[0])
      else $error("inverted polarity falling edge missed");
   a_route_off: assert property (
      !q.smi2[`WAE_B_ROUTE] |=> !q.sts3[`WAE_B_GRP])
      else $error("group status shown while not routed");
   a_grp_gate: assert property (
      q.sts3[`WAE_B_GRP] && q.en3[`WAE_B_GRP] |=> q.pin_sts)
      else $error("enabled group status missed pin status");
   a_wake_pp: assert property (
      act && q.pctl == 8'h83 |=> !wake_request_oe_n_out
      && wake_request_out)
      else $error("push-pull active high wake not driven");
   a_gpio_func: assert property (
      !q.pctl[`WAE_B_FUNC] |=> wake_request_out == $past(gp_pin_val_in)
      && wake_request_oe_n_out == $past(gp_pin_oe_n_in))
      else $error("shared pin left its general purpose function");
   a_key_set: assert property (
      key_evt_in && q.sts6[`WAE_B_KEYEN] |=> q.sts6[`WAE_B_KEY])
      else $error("enabled key event not latched");
   a_key_gate: assert property (
      key_evt_in && !q.sts6[`WAE_B_KEYEN] && !q.sts6[`WAE_B_KEY]
      |=> !q.sts6[`WAE_B_KEY])
      else $error("key event latched while disabled");
   a_bat_reset: assert property (
      bat_por_in |=> !q.sts6[`WAE_B_KEYEN] && q.mwake == 8'h00
      && q.dclk == `WAE_DCLK_RST)
      else $error("battery settings survived battery reset");
   a_mouse_sel: assert property (
      !q.clkcfg[`WAE_B_OFF] && !dwr && mouse_btn_in[1]
      && q.mwake[1:0] == wae_pkg::WAE_SEL_RIGHT |=> q.sts6[`WAE_B_MSE])
      else $error("selected mouse event not latched");
   a_dbl_hit: assert property (
      dbl && q.mst == wae_pkg::WAE_M_WAIT && mouse_btn_in[0]
      && !q.clkcfg[`WAE_B_OFF] && !dwr |=> q.sts6[`WAE_B_MSE])
      else $error("second click in window not latched");
   a_off_quiet: assert property (
      q.clkcfg[`WAE_B_OFF] && !q.sts6[`WAE_B_MSE]
      |=> !q.sts6[`WAE_B_MSE])
      else $error("mouse status set while logic off");
   a_swap_route: assert property (
      q.mwake[`WAE_B_SWAP] |=> kbc_kbd_out == $past(aux_port_in))
      else $error("swapped port not routed to keyboard side");

   // ----------------------------------------
   // Cover points
   // ----------------------------------------
   c_wake: cover property (act ##1 wake_request_out);
   c_dbl: cover property (q.mst == wae_pkg::WAE_M_WAIT ##[1:20] hit);
   c_either_edge_trigger: cover property (fall[0] && q.either_edge_trigger[0]);
   c_key: cover property (key_evt_in && q.sts6[`WAE_B_KEYEN]);
   c_lock: cover property (locked && wr && wb_adr_in == `WAE_A_DCLK);
endmodule : wae_core

// ### wae_chipset_model.sv
`timescale 1ns/100ps
module wae_chipset_model (
   input wire logic pin_out_in,
   input wire logic pin_oe_n_in,
   input wire logic act_hi_in,
   output logic wake_seen_out
);
   // ------
   // Pin sense
   // ------
   logic line;
   // Board pull-up: a released pin reads high, never the last value
   assign line = pin_oe_n_in ? 1'b1 : pin_out_in;
   assign wake_seen_out = (line == act_hi_in);
endmodule : wae_chipset_model

// ### wake_event_aggregator_tb.sv
`timescale 1ns/100ps
`include "wae_params.svh"
module wake_event_aggregator_tb;
   // ------
   // Design and partner
   // ------
   logic clk = 0, rst = 1, bat = 1, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 8'h00, gpio = 8'h00, ev5 = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000, rdat;
   logic grp = 0, key = 0, gval = 0, goe_n = 1, ack, krst;
   logic [1:0] btn = 2'b00;
   logic wake, oe_n, act_hi = 0, seen;
   wae_pkg::wae_ps2_t aux = 2'b11, kbd = 2'b11, kbc_m, kbc_k;
   int error_cnt = 0, checked = 0;
   logic [31:0] exp_q[$];
   always #12.5 clk = ~clk;
   // Short step keeps the double-click window at a few dozen cycles
   wae_core #(.STEP_CYC(4)) dut_u (.sys_clk_in(clk), .sys_rst_in(rst),
      .bat_por_in(bat), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
      .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
      .wb_dat_out(rdat), .wb_ack_out(ack), .gpio_wake_in(gpio),
      .evt5_in(ev5), .grp_irq_in(grp), .key_evt_in(key),
      .mouse_btn_in(btn), .gp_pin_val_in(gval), .gp_pin_oe_n_in(goe_n),
      .aux_port_in(aux), .kbd_port_in(kbd), .kbc_mouse_out(kbc_m),
      .kbc_kbd_out(kbc_k), .kbc_reset_out(krst),
      .wake_request_out(wake), .wake_request_oe_n_out(oe_n));
   wae_chipset_model cs_u (.pin_out_in(wake), .pin_oe_n_in(oe_n),
      .act_hi_in(act_hi), .wake_seen_out(seen));
   // ------
   // Tasks
   // ------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      wdat <= {24'h00_0000, d};
      // No timeout here: only the watchdog ends a wait that never sees ack
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({24'h00_0000, e});
      wb(1'b0, a, 8'h00);
   endtask : rd
   task automatic pin(input logic o, input logic s);
      chk({30'h0000_0000, oe_n, seen}, {30'h0000_0000, o, s});
   endtask : pin
   task automatic click(input logic [1:0] v);
      btn <= v;
      @(posedge clk);
      btn <= 2'b00;
   endtask : click
   // Read answers are compared against the oldest note
   always @(posedge clk) begin
      if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0 && exp_q.size() > 0)
         chk(rdat, exp_q.pop_front());
   end
   initial begin
      tick(20000);
      error_cnt++;
      stop_test();
   end
   initial begin
      int b, s;
      logic [7:0] m;
      void'($urandom(83719));
      tick(8);
      rst <= 1'b0;
      bat <= 1'b0;
      gval <= 1'($urandom_range(1));
      goe_n <= 1'b0;
      tick(4);
      pin(1'b0, ~gval);
      rd(`WAE_A_PCTL, 8'h00);
      rd(`WAE_A_DCLK, {2'b00, `WAE_DCLK_RST});
      rd(`WAE_A_STS6, 8'h00);
      rd(`WAE_A_EN6, 8'h00);
      rd(`WAE_A_CLKCFG, 8'h00);
      rd(8'hFC, 8'h00);
      $display("reset test done");
      b = $urandom_range(7);
      m = 8'h01 << b;
      wb(1, `WAE_A_EN1, 8'hFF);
      wb(1, `WAE_A_PEN, 8'h01);
      wb(1, `WAE_A_PCTL, 8'h01);
      tick(3);
      pin(1'b1, 1'b0);
      gpio <= m;
      tick(6);
      pin(1'b0, 1'b1);
      rd(`WAE_A_STS1, m);
      rd(`WAE_A_PSTS, 8'h01);
      wb(1, `WAE_A_STS1, 8'h00);
      rd(`WAE_A_STS1, m);
      wb(1, `WAE_A_STS1, m);
      wb(1, `WAE_A_PSTS, 8'h01);
      rd(`WAE_A_STS1, 8'h00);
      tick(3);
      pin(1'b1, 1'b0);
      gpio <= 8'h00;
      tick(6);
      rd(`WAE_A_STS1, 8'h00);
      wb(1, `WAE_A_POL, m);
      wb(1, `WAE_A_STS1, 8'hFF);
      gpio <= m;
      tick(6);
      rd(`WAE_A_STS1, 8'h00);
      gpio <= 8'h00;
      tick(6);
      rd(`WAE_A_STS1, m);
      wb(1, `WAE_A_POL, 8'h00);
      wb(1, `WAE_A_EITHER_EDGE_TRIGGER, m);
      wb(1, `WAE_A_STS1, 8'hFF);
      gpio <= m;
      tick(6);
      rd(`WAE_A_STS1, m);
      wb(1, `WAE_A_STS1, m);
      gpio <= 8'h00;
      tick(6);
      rd(`WAE_A_STS1, m);
      wb(1, `WAE_A_STS1, m);
      wb(1, `WAE_A_EITHER_EDGE_TRIGGER, 8'h00);
      wb(1, `WAE_A_PSTS, 8'h01);
      $display("gpio test done");
      wb(1, `WAE_A_PCTL, 8'h83);
      act_hi <= 1'b1;
      wb(1, `WAE_A_PEN, 8'h00);
      wb(1, `WAE_A_EN5, 8'hFF);
      tick(2);
      pin(1'b0, 1'b0);
      ev5 <= m;
      tick(1);
      ev5 <= 8'h00;
      tick(4);
      pin(1'b0, 1'b0);
      rd(`WAE_A_PSTS, 8'h01);
      wb(1, `WAE_A_PEN, 8'h01);
      tick(3);
      pin(1'b0, 1'b1);
      rd(`WAE_A_STS5, m);
      wb(1, `WAE_A_STS5, m);
      wb(1, `WAE_A_PSTS, 8'h01);
      tick(3);
      pin(1'b0, 1'b0);
      wb(1, `WAE_A_SMI2, 8'h20);
      grp <= 1'b1;
      tick(4);
      rd(`WAE_A_STS3, 8'h08);
      rd(`WAE_A_PSTS, 8'h00);
      wb(1, `WAE_A_EN3, 8'h08);
      tick(3);
      rd(`WAE_A_PSTS, 8'h01);
      grp <= 1'b0;
      tick(4);
      rd(`WAE_A_STS3, 8'h00);
      wb(1, `WAE_A_PSTS, 8'h01);
      wb(1, `WAE_A_SMI2, 8'h00);
      grp <= 1'b1;
      tick(4);
      rd(`WAE_A_STS3, 8'h00);
      grp <= 1'b0;
      $display("pin test done");
      wb(1, `WAE_A_STS6, 8'h80);
      key <= 1'b1;
      tick(1);
      key <= 1'b0;
      tick(4);
      rd(`WAE_A_STS6, 8'h81);
      tick(2);
      pin(1'b0, 1'b0);
      wb(1, `WAE_A_EN6, 8'h01);
      tick(3);
      pin(1'b0, 1'b1);
      wb(1, `WAE_A_EN6, 8'h00);
      // Keep the enable set so only battery reset clears it
      wb(1, `WAE_A_STS6, 8'h81);
      wb(1, `WAE_A_PSTS, 8'h01);
      bat <= 1'b1;
      tick(2);
      bat <= 1'b0;
      rd(`WAE_A_STS6, 8'h00);
      key <= 1'b1;
      tick(1);
      key <= 1'b0;
      tick(2);
      rd(`WAE_A_STS6, 8'h00);
      for (s = 1; s < 3; s++) begin
         wb(1, `WAE_A_MWAKE, 8'(s));
         click(2'(3 - s));
         tick(30);
         rd(`WAE_A_STS6, 8'h00);
         click(2'(s));
         tick(30);
         rd(`WAE_A_STS6, 8'h02);
         wb(1, `WAE_A_STS6, 8'h02);
      end
      wb(1, `WAE_A_MWAKE, 8'h03);
      click(2'b01);
      tick(100);
      rd(`WAE_A_STS6, 8'h00);
      click(2'b01);
      tick(8);
      click(2'b01);
      tick(10);
      rd(`WAE_A_STS6, 8'h02);
      wb(1, `WAE_A_STS6, 8'h02);
      click(2'b01);
      wb(1, `WAE_A_DCLK, {2'b00, `WAE_DCLK_RST});
      click(2'b01);
      tick(10);
      rd(`WAE_A_STS6, 8'h00);
      tick(100);
      wb(1, `WAE_A_CLKCFG, 8'h01);
      wb(1, `WAE_A_MWAKE, 8'h00);
      click(2'b10);
      tick(30);
      rd(`WAE_A_STS6, 8'h00);
      wb(1, `WAE_A_CLKCFG, 8'h00);
      click(2'b10);
      tick(30);
      rd(`WAE_A_STS6, 8'h02);
      wb(1, `WAE_A_DCLK, 8'hFF);
      rd(`WAE_A_DCLK, 8'h3F);
      wb(1, `WAE_A_MWAKE, 8'h80);
      wb(1, `WAE_A_DCLK, 8'h05);
      rd(`WAE_A_DCLK, 8'h3F);
      wb(1, `WAE_A_MWAKE, 8'h00);
      rd(`WAE_A_MWAKE, 8'h80);
      bat <= 1'b1;
      tick(2);
      bat <= 1'b0;
      rd(`WAE_A_MWAKE, 8'h00);
      $display("key and mouse test done");
      aux <= 2'($urandom_range(3));
      kbd <= 2'($urandom_range(3));
      tick(3);
      chk({30'h0000_0000, kbc_m, kbc_k}, {30'h0000_0000, aux, kbd});
      wb(1, `WAE_A_MWAKE, 8'h04);
      tick(3);
      chk({30'h0000_0000, kbc_m, kbc_k}, {30'h0000_0000, kbd, aux});
      wb(1, `WAE_A_MWAKE, 8'h00);
      wb(1, `WAE_A_KRG, 8'h02);
      tick(3);
      chk({30'h0000_0000, kbc_m}, 32'h0000_0003);
      wb(1, `WAE_A_KRG, 8'h40);
      tick(2);
      chk({31'h0000_0000, krst}, 32'h0000_0001);
      wb(1, `WAE_A_KRG, 8'h00);
      tick(2);
      chk({31'h0000_0000, krst}, 32'h0000_0000);
      $display("port test done");
      stop_test();
   end
endmodule : wake_event_aggregator_tb
